// file: core/irp_prescaler.sv
// input reference monitor, priority selection and pre-divider
// Notes on behaviour
// - fourteen inputs each watched continuously
// - monitor mode per input: both, activity, off
// - hard frequency limit rejects, soft only flags
// - per-path priorities, highest valid input wins
// - each path automatic or externally commanded selection
// - network rate bit loads from pin, writable
// - direct lock compares at input frequency
// - auto divide bit brings codes 0 to 8 to 8 kHz; other codes, 4'hf among them, pass undivided
// - edge select bit picks locking edge
// - manual bit routes input through shared divider
// - manual divider divides by N plus one
// - N stored in low/high register pair
// - manual mode chosen per input independently
// - 155 MHz direct lock gets divide by two
// - primary path feeds multiplier at 77.76 MHz
// - following auxiliary path locks to primary 8 kHz
// - sync edge resets 2 and 8 kHz dividers
// - 4 or 8 kHz sync pulses accepted too
// - supported spot frequencies including 155.52 MHz
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irp_prescaler (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [irp_pkg::NUM_INPUTS-1:0]      ref_in,
  input  wire logic                                network_type_pin,
  input  wire logic                                two_khz_sync_input,
  input  wire logic                                primary_eight_khz,
  output logic      [irp_pkg::NUM_INPUTS-1:0]      compare_strobe,
  output logic      [irp_pkg::IDX_W-1:0]           primary_source,
  output logic      [irp_pkg::IDX_W-1:0]           auxiliary_source,
  output logic                                     primary_valid,
  output logic                                     auxiliary_valid,
  output logic                                     primary_compare,
  output logic                                     auxiliary_compare,
  output logic                                     network_rate_select,
  output logic                                     low_rate_divider_reset
);
  import irp_pkg::*;

  localparam int N = NUM_INPUTS;

  typedef struct packed {
    logic [N-1:0][7:0]        freq_cfg;
    logic [N-1:0][1:0]        mon_mode;
    logic [N-1:0][PRIO_W-1:0] prio_pri;
    logic [N-1:0][PRIO_W-1:0] prio_aux;
    logic [7:0]               test_ctl;
    logic [7:0]               mode_cfg;
    logic [MANUAL_DIVIDE_W-1:0]        manual_divide;
    logic [15:0]              path_ctl;
    logic [15:0]              hard_lim;
    logic [15:0]              soft_lim;
    logic [N-1:0]             s1;
    logic [N-1:0]             s2;
    logic [N-1:0]             s3;
    logic [N-1:0][15:0]       idle_cnt;
    logic [N-1:0][15:0]       edge_cnt;
    logic [N-1:0][13:0]       div_cnt;
    logic [N-1:0]             act_ok;
    logic [N-1:0]             freq_ok;
    logic [N-1:0]             soft_flag;
    logic [15:0]              win_cnt;
    logic [N-1:0]             strobe;
    logic [IDX_W-1:0]         pri_src;
    logic [IDX_W-1:0]         aux_src;
    logic                     pri_val;
    logic                     aux_val;
    logic                     pri_cmp;
    logic                     aux_cmp;
    logic [2:0]               sync_s;
    logic                     sync_rst;
    logic                     rate_loaded;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     slverr;
  } irp_state_s;

  irp_state_s state_reg;
  irp_state_s state_next;

  logic [9:0] widx;

  assign widx = paddr[11:2];

  always_comb
  begin
    logic [N-1:0] edge_now;
    logic [N-1:0] valid;
    logic [PRIO_W-1:0] best_p;
    logic [PRIO_W-1:0] best_a;
    logic [13:0] ratio;
    logic [IDX_W-1:0] ext_src;
    logic [15:0] count;
    logic wr_go;
    // writes land at the access edge that sees pready, never at setup
    wr_go = psel && penable && state_reg.ready && pwrite;
    edge_now = '0;
    valid = '0;
    best_p = '1;
    best_a = '1;
    ratio = '0;
    ext_src = '0;
    count = '0;
    state_next = state_reg;
    state_next.ready = 1'b0;
    state_next.slverr = 1'b0;
    state_next.strobe = '0;
    // pins pass two flops; s3 feeds only the edge detector
    state_next.s1 = ref_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.sync_s = {state_reg.sync_s[1:0], two_khz_sync_input};
    // rising edge of 2/4/8 kHz sync realigns low-rate dividers
    state_next.sync_rst = state_reg.sync_s[1] & ~state_reg.sync_s[2];
    // network rate loads from the pin once after reset release
    if (!state_reg.rate_loaded)
    begin
      state_next.mode_cfg[MODE_NET_RATE_BIT] = network_type_pin;
      state_next.rate_loaded = 1'b1;
    end
    state_next.win_cnt = (state_reg.win_cnt == WINDOW_CYCLES - 16'h0001) ? '0
                         : state_reg.win_cnt + 16'h0001;
    for (int i = 0; i < N; i++)
    begin
      // lock edge select picks rising or falling edge
      edge_now[i] = state_reg.test_ctl[TEST_EDGE_BIT] ? (state_reg.s3[i] & ~state_reg.s2[i])
                                                        : (state_reg.s2[i] & ~state_reg.s3[i]);
      // every monitor runs all the time
      if (edge_now[i])
        state_next.idle_cnt[i] = '0;
      else if (state_reg.idle_cnt[i] != ACT_TIMEOUT)
        state_next.idle_cnt[i] = state_reg.idle_cnt[i] + 16'h0001;
      state_next.act_ok[i] = (state_reg.idle_cnt[i] != ACT_TIMEOUT);
      count = state_reg.edge_cnt[i] + {15'h0000, edge_now[i]};
      if (state_reg.win_cnt == '0)
      begin
        // frequency checked only while activity is good
        state_next.freq_ok[i] = !state_reg.act_ok[i] || (count <= state_reg.hard_lim);
        state_next.soft_flag[i] = state_reg.act_ok[i] && (count > state_reg.soft_lim);
        state_next.edge_cnt[i] = '0;
      end
      else
        state_next.edge_cnt[i] = count;
      // monitor mode per input
      case (irp_mon_e'(state_reg.mon_mode[i]))
        IRP_MON_OFF:  valid[i] = 1'b1;
        IRP_MON_ACT:  valid[i] = state_reg.act_ok[i];
        IRP_MON_BOTH: valid[i] = state_reg.act_ok[i] & state_reg.freq_ok[i];
        default:      valid[i] = 1'b0;
      endcase
      // pre-divider choice per input, independent of others
      if (state_reg.freq_cfg[i][FREQ_MANUAL_BIT])
        ratio = state_reg.manual_divide + 14'h0001;
      else if (state_reg.freq_cfg[i][FREQ_AUTO8K_BIT])
        ratio = irp_auto_ratio(state_reg.freq_cfg[i][FREQ_CODE_W-1:0]);
      else if (state_reg.freq_cfg[i][FREQ_CODE_W-1:0] == FCODE_155M)
        ratio = 14'h0002;
      else
        ratio = 14'h0001;
      if (edge_now[i])
      begin
        if (state_reg.div_cnt[i] + 14'h0001 >= ratio)
        begin
          state_next.div_cnt[i] = '0;
          state_next.strobe[i] = 1'b1;
        end
        else
          state_next.div_cnt[i] = state_reg.div_cnt[i] + 14'h0001;
      end
    end
    // lower number is higher priority, zero means not eligible
    state_next.pri_val = 1'b0;
    state_next.aux_val = 1'b0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (valid[i] && state_reg.prio_pri[i] != '0 && state_reg.prio_pri[i] <= best_p)
      begin
        best_p = state_reg.prio_pri[i];
        state_next.pri_src = IDX_W'(i);
        state_next.pri_val = 1'b1;
      end
      if (valid[i] && state_reg.prio_aux[i] != '0 && state_reg.prio_aux[i] <= best_a)
      begin
        best_a = state_reg.prio_aux[i];
        state_next.aux_src = IDX_W'(i);
        state_next.aux_val = 1'b1;
      end
    end
    // external selection overrides per path
    if (state_reg.path_ctl[PATH_PRI_EXT_BIT])
    begin
      ext_src = state_reg.path_ctl[PATH_PRI_SRC_LSB +: IDX_W];
      state_next.pri_src = ext_src;
      state_next.pri_val = (ext_src < IDX_W'(N)) && valid[ext_src];
    end
    if (state_reg.path_ctl[PATH_AUX_EXT_BIT])
    begin
      ext_src = state_reg.path_ctl[PATH_AUX_SRC_LSB +: IDX_W];
      state_next.aux_src = ext_src;
      state_next.aux_val = (ext_src < IDX_W'(N)) && valid[ext_src];
    end
    // strobes exceed 77.76 MHz only with auto divide on code 4'hf, the multiplier rate is kept downstream
    state_next.pri_cmp = state_reg.pri_val && state_reg.strobe[state_reg.pri_src];
    // following auxiliary path compares on the primary 8 kHz
    if (state_reg.path_ctl[PATH_AUX_FOLLOW])
      state_next.aux_cmp = primary_eight_khz;
    else
      state_next.aux_cmp = state_reg.aux_val && state_reg.strobe[state_reg.aux_src];
    // apb: no wait state, answer in the cycle after setup
    if ((psel && !penable) || wr_go)
    begin
      state_next.ready = !penable;
      state_next.rdata = '0;
      if (widx >= 10'(IDX_INPUT_FREQ_CONFIG) && widx < 10'(IDX_INPUT_FREQ_CONFIG) + 10'(N))
      begin
        if (wr_go)
          state_next.freq_cfg[widx - 10'(IDX_INPUT_FREQ_CONFIG)] = pwdata[7:0];
        state_next.rdata[7:0] = state_reg.freq_cfg[widx - 10'(IDX_INPUT_FREQ_CONFIG)];
      end
      else if (widx >= 10'(IDX_MONITOR_MODE) && widx < 10'(IDX_MONITOR_MODE) + 10'(N))
      begin
        if (wr_go)
          state_next.mon_mode[widx - 10'(IDX_MONITOR_MODE)] = pwdata[1:0];
        state_next.rdata[1:0] = state_reg.mon_mode[widx - 10'(IDX_MONITOR_MODE)];
      end
      else if (widx >= 10'(IDX_PRIORITY_PRIMARY) && widx < 10'(IDX_PRIORITY_PRIMARY) + 10'(N))
      begin
        if (wr_go)
          state_next.prio_pri[widx - 10'(IDX_PRIORITY_PRIMARY)] = pwdata[PRIO_W-1:0];
        state_next.rdata[PRIO_W-1:0] = state_reg.prio_pri[widx - 10'(IDX_PRIORITY_PRIMARY)];
      end
      else if (widx >= 10'(IDX_PRIORITY_AUXILIARY)
               && widx < 10'(IDX_PRIORITY_AUXILIARY) + 10'(N))
      begin
        if (wr_go)
          state_next.prio_aux[widx - 10'(IDX_PRIORITY_AUXILIARY)] = pwdata[PRIO_W-1:0];
        state_next.rdata[PRIO_W-1:0] = state_reg.prio_aux[widx - 10'(IDX_PRIORITY_AUXILIARY)];
      end
      else
      begin
        case (widx[7:0])
          IDX_TEST_CONTROL_ONE:
          begin
            if (wr_go)
              state_next.test_ctl = pwdata[7:0];
            state_next.rdata[7:0] = state_reg.test_ctl;
          end
          IDX_INPUT_MODE_CONFIG:
          begin
            if (wr_go)
              state_next.mode_cfg = pwdata[7:0];
            state_next.rdata[7:0] = state_reg.mode_cfg;
          end
          // N, not N+1, lives in the pair; out-of-range values are clamped
          IDX_MANUAL_DIVIDER_LOW:
          begin
            if (wr_go)
              state_next.manual_divide[7:0] = pwdata[7:0];
            state_next.rdata[7:0] = state_reg.manual_divide[7:0];
          end
          IDX_MANUAL_DIVIDER_HIGH:
          begin
            if (wr_go)
              state_next.manual_divide[MANUAL_DIVIDE_W-1:8] = pwdata[MANUAL_DIVIDE_W-9:0];
            state_next.rdata[MANUAL_DIVIDE_W-9:0] = state_reg.manual_divide[MANUAL_DIVIDE_W-1:8];
          end
          IDX_PATH_CONTROL:
          begin
            if (wr_go)
              state_next.path_ctl = pwdata[15:0];
            state_next.rdata[15:0] = state_reg.path_ctl;
          end
          IDX_INPUT_STATUS:
            state_next.rdata = {2'b00, state_reg.soft_flag, 2'b00, valid};
          IDX_SELECT_STATUS:
            state_next.rdata[9:0] = {state_reg.aux_val, state_reg.aux_src,
                                     state_reg.pri_val, state_reg.pri_src};
          IDX_HARD_LIMIT:
          begin
            if (wr_go)
              state_next.hard_lim = pwdata[15:0];
            state_next.rdata[15:0] = state_reg.hard_lim;
          end
          IDX_SOFT_LIMIT:
          begin
            if (wr_go)
              state_next.soft_lim = pwdata[15:0];
            state_next.rdata[15:0] = state_reg.soft_lim;
          end
          default:
            state_next.slverr = 1'b1;
        endcase
        if (widx[9:8] != 2'b00)
          state_next.slverr = 1'b1;
      end
      if (penable)
        state_next.slverr = 1'b0;
    end
    if (state_next.manual_divide < MANUAL_DIVIDE_MIN)
      state_next.manual_divide = MANUAL_DIVIDE_MIN;
    else if (state_next.manual_divide > MANUAL_DIVIDE_MAX)
      state_next.manual_divide = MANUAL_DIVIDE_MAX;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.freq_cfg <= {N{FREQ_CFG_RESET}};
      state_reg.mon_mode <= {N{MON_RESET}};
      state_reg.prio_pri <= {4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8,
                             4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
      state_reg.prio_aux <= {4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8,
                             4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
      state_reg.manual_divide <= MANUAL_DIVIDE_RESET;
      state_reg.hard_lim <= HARD_RESET;
      state_reg.soft_lim <= SOFT_RESET;
    end
    else
      state_reg <= state_next;
  end

  // read data registered at setup; write lands at the edge that samples pready
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign compare_strobe = state_reg.strobe;
  assign primary_source = state_reg.pri_src;
  assign auxiliary_source = state_reg.aux_src;
  assign primary_valid = state_reg.pri_val;
  assign auxiliary_valid = state_reg.aux_val;
  assign primary_compare = state_reg.pri_cmp;
  assign auxiliary_compare = state_reg.aux_cmp;
  assign network_rate_select = state_reg.mode_cfg[MODE_NET_RATE_BIT];
  assign low_rate_divider_reset = state_reg.sync_rst;
endmodule
`default_nettype wire

// file: common/irp_pkg.sv
// constants and types for the input reference prescaler
package irp_pkg;
  localparam int NUM_INPUTS = 14;
  localparam int PRIO_W     = 4;
  localparam int IDX_W      = 4;
  localparam int MANUAL_DIVIDE_W     = 14;
  // printed offsets are register indices, byte address is four times the index
  localparam logic [7:0] IDX_TEST_CONTROL_ONE    = 8'h03;
  localparam logic [7:0] IDX_INPUT_FREQ_CONFIG   = 8'h20;
  localparam logic [7:0] IDX_INPUT_MODE_CONFIG   = 8'h34;
  localparam logic [7:0] IDX_MANUAL_DIVIDER_LOW  = 8'h46;
  localparam logic [7:0] IDX_MANUAL_DIVIDER_HIGH = 8'h47;
  // registers of own placement
  localparam logic [7:0] IDX_MONITOR_MODE        = 8'h50;
  localparam logic [7:0] IDX_PRIORITY_PRIMARY    = 8'h60;
  localparam logic [7:0] IDX_PRIORITY_AUXILIARY  = 8'h70;
  localparam logic [7:0] IDX_PATH_CONTROL        = 8'h80;
  localparam logic [7:0] IDX_INPUT_STATUS        = 8'h81;
  localparam logic [7:0] IDX_SELECT_STATUS       = 8'h82;
  localparam logic [7:0] IDX_HARD_LIMIT          = 8'h83;
  localparam logic [7:0] IDX_SOFT_LIMIT          = 8'h84;
  // field positions
  localparam int FREQ_MANUAL_BIT    = 7;
  localparam int FREQ_AUTO8K_BIT    = 6;
  localparam int FREQ_CODE_LSB      = 0;
  localparam int FREQ_CODE_W        = 4;
  localparam int TEST_EDGE_BIT      = 2;
  localparam int MODE_NET_RATE_BIT  = 2;
  localparam int PATH_PRI_EXT_BIT   = 0;
  localparam int PATH_AUX_EXT_BIT   = 1;
  localparam int PATH_AUX_FOLLOW    = 2;
  localparam int PATH_PRI_SRC_LSB   = 8;
  localparam int PATH_AUX_SRC_LSB   = 12;
  // frequency codes; code 4'hf marks a differential 155.52 MHz input
  localparam logic [3:0] FCODE_155M = 4'hf;
  // reset values and manual divider clamp limits
  localparam logic [7:0]  FREQ_CFG_RESET = 8'h00;
  localparam logic [1:0]  MON_RESET      = 2'h2;
  localparam logic [13:0] MANUAL_DIVIDE_RESET     = 14'h00f9;
  localparam logic [15:0] HARD_RESET     = 16'h0100;
  localparam logic [15:0] SOFT_RESET     = 16'h0080;
  localparam logic [13:0] MANUAL_DIVIDE_MIN       = 14'h0001;
  localparam logic [13:0] MANUAL_DIVIDE_MAX       = 14'h30d3;
  // monitor modes
  typedef enum logic [1:0] {
    IRP_MON_OFF  = 2'h0,
    IRP_MON_ACT  = 2'h1,
    IRP_MON_BOTH = 2'h2
  } irp_mon_e;
  // activity timeout and frequency measurement window, in cycles of pclk
  localparam int          WINDOW_US     = 100;
  localparam int          CLK_MHZ       = 40;
  localparam logic [15:0] WINDOW_CYCLES = 16'(WINDOW_US * CLK_MHZ);
  localparam logic [15:0] ACT_TIMEOUT   = 16'h0800;
  // auto divide ratios per frequency code, 8 kHz comparison rate for codes 0 to 8, ratio 1 otherwise
  function automatic logic [13:0] irp_auto_ratio(input logic [3:0] code);
    case (code)
      4'h0: irp_auto_ratio = 14'd1;
      4'h1: irp_auto_ratio = 14'd193;
      4'h2: irp_auto_ratio = 14'd256;
      4'h3: irp_auto_ratio = 14'd810;
      4'h4: irp_auto_ratio = 14'd2430;
      4'h5: irp_auto_ratio = 14'd3240;
      4'h6: irp_auto_ratio = 14'd4860;
      4'h7: irp_auto_ratio = 14'd6480;
      4'h8: irp_auto_ratio = 14'd9720;
      default: irp_auto_ratio = 14'd1;
    endcase
  endfunction
endpackage

// file: tb/irp_properties.sv
// port assertions for the input reference prescaler
`timescale 1ns/1ps
`default_nettype none
module irp_properties (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [11:0]                   paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic                          pready,
  input wire logic                          network_type_pin,
  input wire logic                          two_khz_sync_input,
  input wire logic                          primary_eight_khz,
  input wire logic [irp_pkg::NUM_INPUTS-1:0] compare_strobe,
  input wire logic [irp_pkg::IDX_W-1:0]      primary_source,
  input wire logic                          primary_valid,
  input wire logic                          auxiliary_compare,
  input wire logic                          network_rate_select,
  input wire logic                          low_rate_divider_reset
);
  import irp_pkg::*;
  logic [1:0] rcnt;
  logic       follow_q;
  // follow bit shadowed at the access edge, as the design applies it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcnt     <= 2'h0;
      follow_q <= 1'b0;
    end
    else
    begin
      if (rcnt != 2'h3)
        rcnt <= rcnt + 2'h1;
      if (psel && penable && pready && pwrite && paddr == {2'h0, IDX_PATH_CONTROL, 2'h0})
        follow_q <= pwdata[PATH_AUX_FOLLOW];
    end
  end
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence sync_rise_s;
    $rose(two_khz_sync_input);
  endsequence
  a_apb_answer: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_net_rate_load: assert property (rcnt == 2'h2 |-> network_rate_select == network_type_pin)
    else $error("rate select not loaded from pin");
  a_sync_reset: assert property (sync_rise_s |-> ##[2:4] low_rate_divider_reset)
    else $error("sync edge gave no divider reset");
  a_sync_single: assert property (low_rate_divider_reset |=> !low_rate_divider_reset)
    else $error("divider reset longer than one cycle");
  a_aux_follow: assert property (follow_q && $past(follow_q) |-> auxiliary_compare == $past(primary_eight_khz))
    else $error("auxiliary compare not following primary");
  a_src_range: assert property (primary_valid |-> primary_source < 4'(NUM_INPUTS))
    else $error("selected source out of range");
  a_strobe_pulse: assert property ((compare_strobe & $past(compare_strobe)) == '0)
    else $error("compare strobe longer than one cycle");
endmodule
`default_nettype wire

// file: tb/irp_ref_model.sv
// reference clock and sync pulse sources facing the prescaler
`timescale 1ns/1ps
`default_nettype none
module irp_ref_model #(
  parameter int HALF_NS = 244
)
(
  input  wire logic [13:0] run,
  input  wire logic        sync_go,
  output logic      [13:0] ref_out,
  output logic             sync_out
);
  logic base;
  initial
  begin
    base     = 1'b0;
    ref_out  = 14'h0000;
    sync_out = 1'b0;
  end
  // 2.048 mhz spot frequency, unrelated in phase to pclk
  always #(HALF_NS) base = ~base;
  // a stopped source freezes at its level, as a dead oscillator does
  always @(base)
    ref_out = (ref_out & ~run) | ({14{base}} & run);
  // sync edge lands off the pclk grid to exercise the synchroniser
  always @(posedge sync_go)
  begin
    #40;
    sync_out = 1'b1;
    #2000;
    sync_out = 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the input reference prescaler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irp_pkg::*;
  localparam int REF_NS = 488;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] ref_in, compare_strobe, run;
  logic [3:0]  primary_source, auxiliary_source;
  logic        network_type_pin, two_khz_sync_input, primary_eight_khz, sync_go;
  logic        primary_valid, auxiliary_valid, primary_compare, auxiliary_compare;
  logic        network_rate_select, low_rate_divider_reset;
  int          error_cnt, n_checks, cyc;
  irp_prescaler u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_in(ref_in), .network_type_pin(network_type_pin),
    .two_khz_sync_input(two_khz_sync_input), .primary_eight_khz(primary_eight_khz),
    .compare_strobe(compare_strobe), .primary_source(primary_source),
    .auxiliary_source(auxiliary_source), .primary_valid(primary_valid),
    .auxiliary_valid(auxiliary_valid), .primary_compare(primary_compare),
    .auxiliary_compare(auxiliary_compare), .network_rate_select(network_rate_select),
    .low_rate_divider_reset(low_rate_divider_reset));
  irp_ref_model u_src (.run(run), .sync_go(sync_go), .ref_out(ref_in),
    .sync_out(two_khz_sync_input));
  always #12.5 pclk = ~pclk;
  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, d, rd, err);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    chk(nm, e, rd & 32'hff);
  endtask
  // the first interval may straddle a ratio change, so the second is timed
  task automatic gap(input int i, input int ratio);
    realtime t0;
    real     d;
    @(posedge pclk iff compare_strobe[i] === 1'b1);
    @(posedge pclk iff compare_strobe[i] === 1'b1);
    t0 = $realtime;
    @(posedge pclk iff compare_strobe[i] === 1'b1);
    d = $realtime - t0 - ratio * REF_NS;
    n_checks++;
    if (d > 30.0 || d < -30.0)
    begin
      error_cnt++;
      $display("BAD gap %0d expected %0d seen %0.1f", i, ratio * REF_NS, $realtime - t0);
    end
  endtask
  task automatic t_regs;
    logic [31:0] rd;
    logic        err;
    chk("rate from pin", 32'h1, {31'h0, network_rate_select});
    rdchk("divider low", IDX_MANUAL_DIVIDER_LOW, 32'hf9);
    rdchk("divider high", IDX_MANUAL_DIVIDER_HIGH, 32'h00);
    wr(IDX_INPUT_MODE_CONFIG, 32'h0);
    repeat (2) @(posedge pclk);
    chk("rate by write", 32'h0, {31'h0, network_rate_select});
    wr(IDX_TEST_CONTROL_ONE, 32'h4);
    rdchk("edge select", IDX_TEST_CONTROL_ONE, 32'h4);
    wr(IDX_TEST_CONTROL_ONE, 32'h0);
    apb(1'b0, 8'hff, 32'h0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_divide;
    wr(IDX_MANUAL_DIVIDER_LOW, 32'hff);
    wr(IDX_MANUAL_DIVIDER_HIGH, 32'h00);
    wr(IDX_INPUT_FREQ_CONFIG, 32'h80);
    wr(IDX_INPUT_FREQ_CONFIG + 8'h2, {28'h0, FCODE_155M});
    wr(IDX_INPUT_FREQ_CONFIG + 8'h3, 32'h42);
    wr(IDX_INPUT_FREQ_CONFIG + 8'h4, 32'h80);
    fork
      gap(0, 256);
      gap(1, 1);
      gap(2, 2);
      gap(3, 256);
      gap(4, 256);
    join
  endtask
  task automatic t_select;
    logic [31:0] rd;
    logic        err;
    wr(IDX_HARD_LIMIT, 32'h10);
    repeat (4500) @(posedge pclk);
    apb(1'b0, IDX_INPUT_STATUS, 32'h0, rd, err);
    chk("hard reject", 32'h0, {18'h0, rd[13:0]});
    chk("soft flags", 32'h3fff, {18'h0, rd[29:16]});
    wr(IDX_HARD_LIMIT, 32'h100);
    for (int i = 0; i < 14; i++)
      wr(IDX_MONITOR_MODE + 8'(i), 32'h1);
    repeat (5000) @(posedge pclk);
    chk("primary src", 32'h0, {28'h0, primary_source});
    chk("primary valid", 32'h1, {31'h0, primary_valid});
    @(posedge pclk iff compare_strobe[0] === 1'b1);
    @(posedge pclk);
    chk("primary compare", 32'h1, {31'h0, primary_compare});
    wr(IDX_PRIORITY_PRIMARY, 32'h0);
    repeat (8) @(posedge pclk);
    chk("reselect", 32'h1, {28'h0, primary_source});
    chk("aux kept", 32'h0, {28'h0, auxiliary_source});
    run[1] <= 1'b0;
    repeat (2300) @(posedge pclk);
    chk("input loss", 32'h2, {28'h0, primary_source});
    wr(IDX_MONITOR_MODE + 8'h2, 32'h0);
    run[2] <= 1'b0;
    repeat (2300) @(posedge pclk);
    chk("monitor off", 32'h2, {28'h0, primary_source});
  endtask
  task automatic t_path;
    wr(IDX_PATH_CONTROL, 32'h0701);
    repeat (8) @(posedge pclk);
    chk("ext primary", 32'h7, {28'h0, primary_source});
    wr(IDX_PATH_CONTROL, 32'h3002);
    repeat (8) @(posedge pclk);
    chk("ext aux", 32'h3, {28'h0, auxiliary_source});
    chk("aux valid", 32'h1, {31'h0, auxiliary_valid});
    chk("auto primary", 32'h2, {28'h0, primary_source});
    wr(IDX_PATH_CONTROL, 32'h0004);
    for (int k = 0; k < 4; k++)
    begin
      primary_eight_khz <= k[0];
      repeat (2) @(posedge pclk);
      chk("aux follows", {31'h0, k[0]}, {31'h0, auxiliary_compare});
    end
  endtask
  task automatic t_sync;
    int n;
    n = 0;
    sync_go <= 1'b1;
    repeat (200)
    begin
      @(posedge pclk);
      if (low_rate_divider_reset === 1'b1)
        n++;
    end
    sync_go <= 1'b0;
    chk("sync resets", 32'h1, 32'(n));
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, primary_eight_khz, sync_go} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    network_type_pin = 1'b1;
    run = 14'h3fff;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_divide();
    t_select();
    t_path();
    t_sync();
    close_out();
  end
endmodule
bind irp_prescaler irp_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .network_type_pin(network_type_pin), .two_khz_sync_input(two_khz_sync_input),
  .primary_eight_khz(primary_eight_khz), .compare_strobe(compare_strobe),
  .primary_source(primary_source), .primary_valid(primary_valid),
  .auxiliary_compare(auxiliary_compare), .network_rate_select(network_rate_select),
  .low_rate_divider_reset(low_rate_divider_reset));
`default_nettype wire
